// ### lcs_ctrl_model.sv
// Controller model: scan clock, scan data on the chosen chain ends, AC phase
`timescale 1ns/1ps

module lcs_ctrl_model (
   input  wire logic i_mclk,
   input  wire logic i_dir,
   input  wire logic i_frame,
   output logic      o_scan_clk,
   output logic      o_ac_phase,
   output logic      o_a_low,
   output logic      o_a_high,
   output logic      o_b_low,
   output logic      o_b_high
);
   logic a_r;
   logic b_r;
   logic vld_r;

   // Clock parked low between pulses, no data held
   initial begin
      o_scan_clk = 1'b0;
      a_r = 1'b0;
      b_r = 1'b0;
      vld_r = 1'b0;
   end

   //////////////////////////////////////////////////////////////////////////
   // phase from inverted frame
   assign o_ac_phase = ~i_frame;

   // data on input end
   // Released lines show the inverse of the last bit, so a stale sample cannot pass
   assign o_a_low  = (vld_r && !i_dir) ? a_r : ~a_r;
   assign o_b_low  = (vld_r && !i_dir) ? b_r : ~b_r;
   assign o_a_high = (vld_r && i_dir) ? a_r : ~a_r;
   assign o_b_high = (vld_r && i_dir) ? b_r : ~b_r;

   // One scan pulse: high for hi cycles, then low; data held past the sampling edge
   task automatic send(input logic a, input logic b, input int hi);
      @(negedge i_mclk);
      a_r = a;
      b_r = b;
      vld_r = 1'b1;
      o_scan_clk = 1'b1;
      repeat (hi) @(negedge i_mclk);
      o_scan_clk = 1'b0;
      @(negedge i_mclk);
      @(negedge i_mclk);
      vld_r = 1'b0;
   endtask
endmodule

// ### lcs_defs.svh
// Constants for the common scan driver: lengths, level codes, buffer sizes
`ifndef LCS_DEFS_SVH
`define LCS_DEFS_SVH

// Scan chain geometry
`define LCS_CHAIN_LEN   80
`define LCS_NUM_OUTS    160
`define LCS_DRV_W       320

// Two-bit drive level codes, one per common output
`define LCS_LVL_ONE     2'h0
`define LCS_LVL_TWO     2'h1
`define LCS_LVL_FIVE    2'h2
`define LCS_LVL_LOWEST  2'h3

// Scan event buffer: word is {direction, chain a bit, chain b bit}
`define LCS_FIFO_W      3
`define LCS_FIFO_DEPTH  8
`define LCS_FW_DIR      2
`define LCS_FW_A        1
`define LCS_FW_B        0

`endif

// ### lcs_fifo.sv
// Small flip-flop FIFO holding captured scan events
`timescale 1ns/1ps
`include "lcs_defs.svh"

module lcs_fifo #(
   parameter int WIDTH = `LCS_FIFO_W,
   parameter int DEPTH = `LCS_FIFO_DEPTH
) (
   input  wire logic    i_mclk,
   input  wire logic    i_rst,
   lcs_fifo_if.buf_side io
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [CW-1:0]               cnt;
   } lcs_fifo_state_t;

   lcs_fifo_state_t st_r;
   lcs_fifo_state_t st_nxt;
   logic            push_fire;
   logic            pop_fire;

   // Honest flags straight from the count
   assign io.push_ready = (st_r.cnt != CW'(DEPTH));
   assign io.pop_valid  = (st_r.cnt != '0);
   assign io.pop_data   = st_r.mem[st_r.rp];
   assign push_fire     = io.push_valid & io.push_ready;
   assign pop_fire      = io.pop_valid & io.pop_ready;

   // Pointer and count update; simultaneous push and pop keeps count
   always_comb begin
      st_nxt = st_r;
      if (push_fire) begin
         st_nxt.mem[st_r.wp] = io.push_data;
         st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + AW'(1);
      end
      if (pop_fire) begin
         st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + AW'(1);
      end
      if (push_fire && !pop_fire) begin
         st_nxt.cnt = st_r.cnt + CW'(1);
      end else if (pop_fire && !push_fire) begin
         st_nxt.cnt = st_r.cnt - CW'(1);
      end
   end

   // State register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   fifo_bound_a: assert property (@(posedge i_mclk) disable iff (i_rst) st_r.cnt <= CW'(DEPTH))
      else $error("fifo count above depth");

endmodule

// ### lcs_fifo_if.sv
// Handshake bundle between the scan driver and its event buffer
`timescale 1ns/1ps
`include "lcs_defs.svh"

interface lcs_fifo_if;
   logic                    push_valid;
   logic                    push_ready;
   logic [`LCS_FIFO_W-1:0]  push_data;
   logic                    pop_valid;
   logic                    pop_ready;
   logic [`LCS_FIFO_W-1:0]  pop_data;

   modport src (
      output push_valid,
      output push_data,
      output pop_ready,
      input  push_ready,
      input  pop_valid,
      input  pop_data
   );

   modport buf_side (
      input  push_valid,
      input  push_data,
      input  pop_ready,
      output push_ready,
      output pop_valid,
      output pop_data
   );
endinterface

// ### lcs_pkg.sv
// Types shared by the common scan driver modules
`include "lcs_defs.svh"

package lcs_pkg;

   typedef logic [1:0] lcs_level_t;

   // Whole state of the scan driver top
   typedef struct packed {
      logic                         scan_prev;
      logic [`LCS_CHAIN_LEN-1:0]    chain_a;
      logic [`LCS_CHAIN_LEN-1:0]    chain_b;
      logic [`LCS_DRV_W-1:0]        drive;
      logic                         a_lo_out;
      logic                         a_lo_oe;
      logic                         a_hi_out;
      logic                         a_hi_oe;
      logic                         b_lo_out;
      logic                         b_lo_oe;
      logic                         b_hi_out;
      logic                         b_hi_oe;
      logic                         ready;
   } lcs_state_t;

endpackage

// ### lcs_scan_driver.sv
// Common scan driver core: two 80-bit scan chains and 4-level output select
`timescale 1ns/1ps
`include "lcs_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Two independent 80-bit scan chains
// - Chains advance on scan clock falling edge
// - Direction low: low end in, high out
// - Direction high: high end in, low out
// - One scan clock shifts both chains together
// - Blank low forces all outputs level one
// - Phase and bit pick the level otherwise
// - One bit per output, four levels
module lcs_scan_driver
   import lcs_pkg::*;
(
   input  wire logic                    i_mclk,
   input  wire logic                    i_rst,
   input  wire logic                    i_scan_clk,
   input  wire logic                    i_shift_dir_sel,
   input  wire logic                    i_ac_phase_in,
   input  wire logic                    i_blank_n,
   input  wire logic                    i_shift_hold,
   input  wire logic                    i_chain_a_low_end,
   output logic                         o_chain_a_low_end,
   output logic                         o_chain_a_low_end_oe,
   input  wire logic                    i_chain_a_high_end,
   output logic                         o_chain_a_high_end,
   output logic                         o_chain_a_high_end_oe,
   input  wire logic                    i_chain_b_low_end,
   output logic                         o_chain_b_low_end,
   output logic                         o_chain_b_low_end_oe,
   input  wire logic                    i_chain_b_high_end,
   output logic                         o_chain_b_high_end,
   output logic                         o_chain_b_high_end_oe,
   output logic                         o_scan_ready,
   output logic [`LCS_DRV_W-1:0]        o_common_drive_out
);

   //////////////////////////////////////////////////////////////////////////
   // Level selection

   // Map one chain bit plus phase and blank onto a level code
   function automatic lcs_level_t lvl_sel(input logic bit_v, input logic phase, input logic blank_n);
      lcs_level_t lvl;
      lvl = `LCS_LVL_ONE;
      if (blank_n) begin
         // phase and bit table
         // Select levels for a set bit, non-select levels for a clear one
         unique case ({phase, bit_v})
            2'h0: lvl = `LCS_LVL_TWO;
            2'h1: lvl = `LCS_LVL_LOWEST;
            2'h2: lvl = `LCS_LVL_FIVE;
            2'h3: lvl = `LCS_LVL_ONE;
         endcase
      end
      return lvl;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Declarations

   lcs_state_t st_r;
   lcs_state_t st_nxt;
   lcs_fifo_if fq ();
   logic       scan_fall;
   logic       pop_fire;
   logic       pop_dir;
   logic       pop_a;
   logic       pop_b;

   //////////////////////////////////////////////////////////////////////////
   // Event capture and buffer

   // scan clock falling edge
   // Falling edge of the scan clock, sampled as a plain input
   // Limitation: each scan clock level must last at least one mclk
   assign scan_fall = st_r.scan_prev & ~i_scan_clk;

   // Capture the entry bit from whichever end the direction makes an input
   assign fq.push_valid = scan_fall;
   assign fq.push_data  = {i_shift_dir_sel,
                           i_shift_dir_sel ? i_chain_a_high_end : i_chain_a_low_end,
                           i_shift_dir_sel ? i_chain_b_high_end : i_chain_b_low_end};

   // Hold lets the shifter stall; the buffer then fills and warns upstream
   assign fq.pop_ready = ~i_shift_hold;
   assign pop_fire     = fq.pop_valid & fq.pop_ready;
   assign pop_dir      = fq.pop_data[`LCS_FW_DIR];
   assign pop_a        = fq.pop_data[`LCS_FW_A];
   assign pop_b        = fq.pop_data[`LCS_FW_B];

   // Eight-deep buffer rides out a held shifter; deeper only costs flops
   lcs_fifo #(
      .WIDTH (`LCS_FIFO_W),
      .DEPTH (`LCS_FIFO_DEPTH)
   ) u_fifo (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .io     (fq)
   );

   //////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt = st_r;
      st_nxt.scan_prev = i_scan_clk;
      st_nxt.ready     = fq.push_ready;
      // shared shift event
      // One popped event moves both chains in the same cycle
      // two 80-bit chains
      if (pop_fire) begin
         if (!pop_dir) begin
            st_nxt.chain_a = {st_r.chain_a[`LCS_CHAIN_LEN-2:0], pop_a};
            st_nxt.chain_b = {st_r.chain_b[`LCS_CHAIN_LEN-2:0], pop_b};
         end else begin
            st_nxt.chain_a = {pop_a, st_r.chain_a[`LCS_CHAIN_LEN-1:1]};
            st_nxt.chain_b = {pop_b, st_r.chain_b[`LCS_CHAIN_LEN-1:1]};
         end
      end
      // cascade end pins
      // Far end shows the last bit; enables follow the live direction pin
      st_nxt.a_hi_out = st_nxt.chain_a[`LCS_CHAIN_LEN-1];
      st_nxt.b_hi_out = st_nxt.chain_b[`LCS_CHAIN_LEN-1];
      st_nxt.a_lo_out = st_nxt.chain_a[0];
      st_nxt.b_lo_out = st_nxt.chain_b[0];
      st_nxt.a_hi_oe  = ~i_shift_dir_sel;
      st_nxt.b_hi_oe  = ~i_shift_dir_sel;
      st_nxt.a_lo_oe  = i_shift_dir_sel;
      st_nxt.b_lo_oe  = i_shift_dir_sel;
      // one code per bit
      // Level codes follow the chain state one cycle later
      for (int k = 0; k < `LCS_CHAIN_LEN; k++) begin
         st_nxt.drive[2*k +: 2] = lvl_sel(st_r.chain_a[k], i_ac_phase_in, i_blank_n);
         st_nxt.drive[2*(k+`LCS_CHAIN_LEN) +: 2] = lvl_sel(st_r.chain_b[k], i_ac_phase_in, i_blank_n);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // State register

   // Chains start clear; reset loads level one codes, then outputs idle at non-select levels one cycle later
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Outputs, all from the state register
   // Registered pins keep decode glitches off the cascade and level shifters

   assign o_chain_a_low_end     = st_r.a_lo_out;
   assign o_chain_a_low_end_oe  = st_r.a_lo_oe;
   assign o_chain_a_high_end    = st_r.a_hi_out;
   assign o_chain_a_high_end_oe = st_r.a_hi_oe;
   assign o_chain_b_low_end     = st_r.b_lo_out;
   assign o_chain_b_low_end_oe  = st_r.b_lo_oe;
   assign o_chain_b_high_end    = st_r.b_hi_out;
   assign o_chain_b_high_end_oe = st_r.b_hi_oe;
   assign o_scan_ready          = st_r.ready;
   assign o_common_drive_out    = st_r.drive;

   //////////////////////////////////////////////////////////////////////////
   // Checks

   shift_up_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      pop_fire && !pop_dir |=> st_r.chain_a == {$past(st_r.chain_a[78:0]), $past(pop_a)})
      else $error("upward shift of chain a wrong");

   shift_down_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      pop_fire && pop_dir |=> st_r.chain_b == {$past(pop_b), $past(st_r.chain_b[79:1])})
      else $error("downward shift of chain b wrong");

   chain_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      !pop_fire |=> $stable(st_r.chain_a) && $stable(st_r.chain_b))
      else $error("chain moved without scan event");

   joint_shift_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      pop_fire && !pop_dir |=> st_r.chain_b[0] == $past(pop_b) && st_r.chain_a[0] == $past(pop_a))
      else $error("chains did not shift together");

   blank_force_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      !i_blank_n |=> o_common_drive_out == {`LCS_NUM_OUTS{`LCS_LVL_ONE}})
      else $error("blanking did not force level one");

   level_table_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_blank_n && !i_ac_phase_in && st_r.chain_a[0] |=> o_common_drive_out[1:0] == `LCS_LVL_LOWEST)
      else $error("phase low bit high not lowest level");

   nonsel_level_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_blank_n && i_ac_phase_in && !st_r.chain_b[79] |=> o_common_drive_out[319:318] == `LCS_LVL_FIVE)
      else $error("phase high bit low not level five");

   bit_map_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_blank_n && !i_ac_phase_in ##1 i_blank_n && !i_ac_phase_in
      |-> o_common_drive_out[41:40] == ($past(st_r.chain_a[20]) ? `LCS_LVL_LOWEST : `LCS_LVL_TWO))
      else $error("output 20 does not follow its chain bit");

   far_end_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      ##1 o_chain_a_high_end == st_r.chain_a[79] && o_chain_b_low_end == st_r.chain_b[0])
      else $error("chain end pin not last bit");

   chain_b_up_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      pop_fire && !pop_dir |=> st_r.chain_b == {$past(st_r.chain_b[78:0]), $past(pop_b)})
      else $error("upward shift of chain b wrong");

   chain_a_down_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      pop_fire && pop_dir |=> st_r.chain_a == {$past(pop_a), $past(st_r.chain_a[79:1])})
      else $error("downward shift of chain a wrong");

   // high ends drive when direction low
   high_end_oe_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      1'b1 |=> o_chain_a_high_end_oe == !$past(i_shift_dir_sel)
               && o_chain_b_high_end_oe == !$past(i_shift_dir_sel))
      else $error("high end enable does not follow direction");

   // low ends drive when direction high
   low_end_oe_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      1'b1 |=> o_chain_a_low_end_oe == $past(i_shift_dir_sel)
               && o_chain_b_low_end_oe == $past(i_shift_dir_sel))
      else $error("low end enable does not follow direction");

   cascade_end_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      ##1 o_chain_a_low_end == st_r.chain_a[0] && o_chain_b_high_end == st_r.chain_b[79])
      else $error("cascade pin not chain end bit");

   level_two_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_blank_n && !i_ac_phase_in && !st_r.chain_a[0] |=> o_common_drive_out[1:0] == `LCS_LVL_TWO)
      else $error("phase low bit low not level two");

   level_one_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_blank_n && i_ac_phase_in && st_r.chain_b[1] |=> o_common_drive_out[163:162] == `LCS_LVL_ONE)
      else $error("phase high bit high not level one");

   level_low_b_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_blank_n && !i_ac_phase_in && st_r.chain_b[79] |=> o_common_drive_out[319:318] == `LCS_LVL_LOWEST)
      else $error("last output not lowest level");

   level_five_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_blank_n && i_ac_phase_in && !st_r.chain_a[78] |=> o_common_drive_out[157:156] == `LCS_LVL_FIVE)
      else $error("output 78 not level five");

   bit_map_b_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_blank_n && i_ac_phase_in ##1 i_blank_n && i_ac_phase_in
      |-> o_common_drive_out[201:200] == ($past(st_r.chain_b[20]) ? `LCS_LVL_ONE : `LCS_LVL_FIVE))
      else $error("output 100 does not follow its chain bit");

   // codes follow only their inputs
   // Reset leaves stale history, so the first cycle after it is skipped
   drive_steady_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      !$past(i_rst) && $stable(st_r.chain_a) && $stable(st_r.chain_b) && $stable(i_ac_phase_in)
      && $stable(i_blank_n) |=> $stable(o_common_drive_out))
      else $error("drive codes moved with steady inputs");

   hold_still_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_shift_hold |=> $stable(st_r.chain_a) && $stable(st_r.chain_b))
      else $error("chain moved while held");

   event_pop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      scan_fall && !fq.pop_valid ##1 !i_shift_hold |-> pop_fire)
      else $error("scan event not taken promptly");

   full_warn_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      !fq.push_ready |=> !o_scan_ready)
      else $error("ready high with buffer full");

   // Main scenarios
   cov_shift_up: cover property (@(posedge i_mclk) disable iff (i_rst) pop_fire && !pop_dir);
   cov_shift_down: cover property (@(posedge i_mclk) disable iff (i_rst) pop_fire && pop_dir);
   cov_full: cover property (@(posedge i_mclk) disable iff (i_rst) !fq.push_ready && scan_fall);
   cov_blank: cover property (@(posedge i_mclk) disable iff (i_rst) !i_blank_n ##1 i_blank_n);
   cov_hold: cover property (@(posedge i_mclk) disable iff (i_rst) i_shift_hold && scan_fall);

endmodule

// ### lcs_scan_driver_tb.sv
// Self-checking testbench for the common scan driver core
`timescale 1ns/1ps
`include "lcs_defs.svh"

module lcs_scan_driver_tb
   import lcs_pkg::*;
;
   logic                  mclk = 1'b0;
   logic                  rst = 1'b1;
   logic                  dir = 1'b0;
   logic                  frame = 1'b1;
   logic                  blank_n = 1'b1;
   logic                  hold = 1'b0;
   logic                  scan_clk;
   logic                  phase;
   logic                  m_alo, m_ahi, m_blo, m_bhi;
   logic                  alo, aloe, ahi, ahie, blo, bloe, bhi, bhie;
   logic                  ready;
   logic [`LCS_DRV_W-1:0] drive;
   logic [79:0]           ca = '0;
   logic [79:0]           cb = '0;
   int                    mismatches = 0;
   int                    cmp_count = 0;

   always #4 mclk = ~mclk;

   lcs_ctrl_model i_ctl (.i_mclk(mclk), .i_dir(dir), .i_frame(frame), .o_scan_clk(scan_clk),
      .o_ac_phase(phase), .o_a_low(m_alo), .o_a_high(m_ahi), .o_b_low(m_blo), .o_b_high(m_bhi));

   // Pin level: the driving end wins, otherwise the controller's line
   lcs_scan_driver i_dut (.i_mclk(mclk), .i_rst(rst), .i_scan_clk(scan_clk),
      .i_shift_dir_sel(dir), .i_ac_phase_in(phase), .i_blank_n(blank_n), .i_shift_hold(hold),
      .i_chain_a_low_end(aloe ? alo : m_alo), .o_chain_a_low_end(alo), .o_chain_a_low_end_oe(aloe),
      .i_chain_a_high_end(ahie ? ahi : m_ahi), .o_chain_a_high_end(ahi), .o_chain_a_high_end_oe(ahie),
      .i_chain_b_low_end(bloe ? blo : m_blo), .o_chain_b_low_end(blo), .o_chain_b_low_end_oe(bloe),
      .i_chain_b_high_end(bhie ? bhi : m_bhi), .o_chain_b_high_end(bhi), .o_chain_b_high_end_oe(bhie),
      .o_scan_ready(ready), .o_common_drive_out(drive));

   //////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [`LCS_DRV_W-1:0] got, input logic [`LCS_DRV_W-1:0] exp,
                        input string msg);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s", $time, msg);
      end
   endtask

   task automatic test_done();
      $display("checks=%0d mismatches=%0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Expected level codes from the chain model, phase and blanking
   function automatic logic [`LCS_DRV_W-1:0] exp_drive();
      logic [`LCS_DRV_W-1:0] d;
      logic                  bt;
      for (int k = 0; k < `LCS_NUM_OUTS; k++) begin
         bt = (k < 80) ? ca[k] : cb[k-80];
         if (!blank_n) d[2*k+:2] = `LCS_LVL_ONE;
         else if (phase) d[2*k+:2] = bt ? `LCS_LVL_ONE : `LCS_LVL_FIVE;
         else d[2*k+:2] = bt ? `LCS_LVL_LOWEST : `LCS_LVL_TWO;
      end
      return d;
   endfunction

   // One scan event; keep=0 when the event is expected to be dropped
   task automatic shift(input logic a, input logic b, input int hi, input logic keep);
      i_ctl.send(a, b, hi);
      if (keep && dir) begin
         ca = {a, ca[79:1]};
         cb = {b, cb[79:1]};
      end else if (keep) begin
         ca = {ca[78:0], a};
         cb = {cb[78:0], b};
      end
   endtask

   //////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      repeat (2) @(negedge mclk);
      check(drive, exp_drive(), "drive after reset");
      check({aloe, ahie, bloe, bhie}, 4'h5, "end enables dir low");
      check(ready, 1'b1, "ready after reset");
   endtask

   // Fill both chains in one direction, prompt and slow pulses mixed
   task automatic t_fill(input logic d);
      dir = d;
      repeat (3) @(negedge mclk);
      check({aloe, ahie, bloe, bhie}, d ? 4'ha : 4'h5, "end enables");
      for (int i = 0; i < 80; i++) begin
         shift((i % 3 == 0) ^ d, (i % 7 == 1) ^ d, (i % 4 == 0) ? 3 : 1, 1'b1);
      end
      repeat (4) @(negedge mclk);
      check(drive, exp_drive(), "drive after fill");
      check(d ? {alo, blo} : {ahi, bhi}, {~d, d}, "first bit at far end");
   endtask

   // Every phase and blanking combination over a mixed chain
   task automatic t_levels();
      for (int i = 0; i < 4; i++) begin
         frame = i[0];
         blank_n = i[1];
         repeat (2) @(negedge mclk);
         check(drive, exp_drive(), "level select");
      end
   endtask

   // Stall: 8 events fill the buffer, the ninth is dropped
   task automatic t_hold();
      logic [`LCS_DRV_W-1:0] snap;
      snap = exp_drive();
      hold = 1'b1;
      for (int i = 0; i < 9; i++) begin
         shift(i[0], ~i[1], 1, i < 8);
      end
      check(drive, snap, "no shift while held");
      check(ready, 1'b0, "buffer full");
      hold = 1'b0;
      repeat (14) @(negedge mclk);
      check(drive, exp_drive(), "drained events");
      check(ready, 1'b1, "buffer drained");
   endtask

   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      t_reset();
      t_fill(1'b0);
      t_levels();
      t_fill(1'b1);
      t_hold();
      test_done();
   end

   // Watchdog: the whole sequence needs under 2000 clocks
   initial begin
      #100000;
      mismatches++;
      test_done();
   end
endmodule
